// >>> design/sync_stage.sv
// One synchrocheck stage: classification, differences, request timer, fail pulse.
// Assumes one ms tick enable from the parent and measurements synchronous to the clock.
`timescale 1ns/1ps
module sync_stage
  import synchro_pkg::*;
(
  input  wire logic                    core_clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    tick_i,
  input  wire synchro_pkg::meas_t      ref_i,
  input  wire synchro_pkg::meas_t      cmp_i,
  input  wire synchro_pkg::stage_cfg_t cfg_i,
  input  wire logic                    bypass_i,
  input  wire logic                    close_cmd_i,
  output synchro_pkg::stage_out_t      out_o
);
  import synchro_pkg::*;

  typedef enum {ST_IDLE, ST_REQ, ST_FAIL} st_t;

  st_t               state;
  logic [TW-1:0]     timer;
  logic [TW-1:0]     fail_cnt;
  logic              ref_dead, ref_live, cmp_dead, cmp_live;
  logic [VW-1:0]     du;
  logic [FW-1:0]     df;
  logic [AW-1:0]     raw_dphi, dphi;
  logic              volt_ok, fp_ok, in_window, aimed, synced;
  logic [31:0]       adv_angle;

  // ************************************************************
  // Dead and live classification
  // ************************************************************
  assign ref_dead = ref_i.amp < cfg_i.dead_limit;
  assign cmp_dead = cmp_i.amp < cfg_i.dead_limit;
  assign ref_live = ref_i.amp > cfg_i.live_limit;
  assign cmp_live = cmp_i.amp > cfg_i.live_limit;

  // ************************************************************
  // Differences between the two sides
  // ************************************************************
  // Absolute values; the angle wraps so the shorter way is taken
  assign du       = (ref_i.amp > cmp_i.amp) ? ref_i.amp - cmp_i.amp
                                            : cmp_i.amp - ref_i.amp;
  assign df       = (ref_i.freq > cmp_i.freq) ? ref_i.freq - cmp_i.freq
                                              : cmp_i.freq - ref_i.freq;
  assign raw_dphi = (ref_i.angle > cmp_i.angle) ? ref_i.angle - cmp_i.angle
                                                : cmp_i.angle - ref_i.angle;
  assign dphi     = (raw_dphi > ANGLE_HALF) ? ANGLE_FULL - raw_dphi : raw_dphi;

  // ************************************************************
  // Criteria
  // ************************************************************
  // First letter is reference side, second is comparison side
  assign volt_ok = (cfg_i.volt_check_sel[VC_BOTH_DEAD]   && ref_dead && cmp_dead)
                || (cfg_i.volt_check_sel[VC_REF_D_CMP_L] && ref_dead && cmp_live)
                || (cfg_i.volt_check_sel[VC_REF_L_CMP_D] && ref_live && cmp_dead);

  // Phase advance = slip (mHz) * close time (ms) * 360 deg, in 0.01 deg units
  assign adv_angle = 32'(df) * 32'(cfg_i.close_time_ms) * 32'd36 / 32'd1000;
  assign in_window = dphi <= cfg_i.max_dphi;
  assign aimed     = (cfg_i.mode == SMODE_SYNC)
                   ? (32'(dphi) <= adv_angle + 32'(cfg_i.max_dphi) / 32'd8)
                   : in_window;
  assign fp_ok = (cfg_i.mode != SMODE_OFF) && ref_live && cmp_live
              && du <= cfg_i.max_du && df <= cfg_i.max_df && in_window && aimed;

  // Either criterion alone, or either one of the two when both are enabled
  always_comb
  begin
    if (bypass_i)
      synced = 1'b1;
    else if (cfg_i.volt_check_en && cfg_i.mode != SMODE_OFF)
      synced = volt_ok || fp_ok;
    else if (cfg_i.mode != SMODE_OFF)
      synced = fp_ok;
    else
      synced = cfg_i.volt_check_en && volt_ok;
  end

  // ************************************************************
  // Request sequencing
  // ************************************************************
  // Close command only opens a request; repeats during a request are dropped
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      state <= ST_IDLE;
    else
      case (state)
        ST_IDLE:
          if (close_cmd_i)
            state <= ST_REQ;
        ST_REQ:
          if (synced)
            state <= ST_IDLE;
          else if (tick_i && timer + 1'b1 >= cfg_i.timeout_ms)
            state <= ST_FAIL;
        ST_FAIL:
          if (tick_i && fail_cnt + 1'b1 >= TW'(FAIL_PULSE_TICKS))
            state <= ST_IDLE;
        default:
          state <= ST_IDLE;
      endcase
  end

  // Timeout timer, cleared whenever idle
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i || state != ST_REQ)
      timer <= '0;
    else if (tick_i)
      timer <= timer + 1'b1;
  end

  // Fail pulse length counter, independent of settings
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i || state != ST_FAIL)
      fail_cnt <= '0;
    else if (tick_i)
      fail_cnt <= fail_cnt + 1'b1;
  end

  // Registered indications
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      out_o <= '0;
    else
    begin
      out_o.request   <= (state == ST_REQ) && !synced
                      && !(tick_i && timer + 1'b1 >= cfg_i.timeout_ms);
      out_o.ok        <= synced;
      out_o.fail      <= state == ST_FAIL;
      out_o.close_cmd <= (state == ST_REQ) && synced;
    end
  end

endmodule

// >>> common/synchro_pkg.sv
// Package for the synchrocheck close control block.
// Assumes a 25 MHz core clock; all measurements arrive as unsigned scaled numbers.
package synchro_pkg;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int unsigned CLK_HZ         = 25_000_000;
  localparam int unsigned TICK_US        = 1000;           // Timebase tick, 1 ms
  localparam int unsigned TICK_CYCLES    = CLK_HZ / 1_000_000 * TICK_US;
  localparam int unsigned FAIL_PULSE_MS  = 200;            // Fixed fail pulse
  localparam int unsigned FAIL_PULSE_TICKS = FAIL_PULSE_MS * 1000 / TICK_US;
  localparam int unsigned REQ_TIMEOUT_DEF_MS = 10_000;     // Default request timeout

  // ************************************************************
  // Widths and codes
  // ************************************************************
  localparam int unsigned VW = 16;   // Voltage, fraction of nominal
  localparam int unsigned FW = 16;   // Frequency and frequency difference, mHz
  localparam int unsigned AW = 16;   // Phase angle
  localparam int unsigned TW = 20;   // Millisecond counters

  // Voltage-check selection bits; any OR of the three codes is allowed
  localparam int unsigned VC_BOTH_DEAD  = 0;
  localparam int unsigned VC_REF_D_CMP_L = 1;
  localparam int unsigned VC_REF_L_CMP_D = 2;

  // Synchronism mode
  typedef enum logic [1:0] {SMODE_OFF, SMODE_ASYNC, SMODE_SYNC} sync_mode_t;

  // Stage two input pair selection
  typedef enum logic [1:0] {PAIR_MAIN_Y, PAIR_MAIN_Z, PAIR_Y_Z} pair_sel_t;

  // One measured side
  typedef struct packed {
    logic [VW-1:0] amp;     // Amplitude
    logic [FW-1:0] freq;    // Frequency, mHz
    logic [AW-1:0] angle;   // Phase angle, 0.01 degree units over 0..35999
  } meas_t;

  // Per-stage settings
  typedef struct packed {
    logic          volt_check_en;  // Voltage-only criterion in use
    logic [2:0]    volt_check_sel;
    sync_mode_t    mode;
    logic [VW-1:0] dead_limit;
    logic [VW-1:0] live_limit;
    logic [VW-1:0] max_du;
    logic [FW-1:0] max_df;
    logic [AW-1:0] max_dphi;
    logic [TW-1:0] close_time_ms;
    logic [TW-1:0] timeout_ms;
  } stage_cfg_t;

  // Per-stage indications
  typedef struct packed {
    logic request;
    logic ok;
    logic fail;
    logic close_cmd;
  } stage_out_t;

  localparam logic [AW-1:0] ANGLE_FULL = 16'h8CA0;  // 360.00 degrees
  localparam logic [AW-1:0] ANGLE_HALF = 16'h4650;  // 180.00 degrees

endpackage

// >>> design/synchrocheck_close_control.sv
// Top of the synchrocheck close control: two stages, pair selection, ms timebase.
// Assumes measurement front ends deliver settled values each cycle and
// the settings stay stable; the close command from each stage stays internal
// and only feeds the breaker close path port.
//
// Behaviour
// - close command only opens a request
// - request held until synchronism or timeout
// - timeout gives fail pulse, no close
// - fail pulse fixed at 200 ms
// - synchronism within time issues internal close
// - OK follows synchronism continuously
// - bypass forces synchronism true
// - below dead limit means dead
// - above live limit means live
// - voltage-only criterion from dead/live code
// - frequency-phase needs live sides, limits met
// - zero-phase mode advances by closing time
// - window mode closes at limit entry
// - criteria selectable alone or combined
// - request, OK, fail exported as outputs
// - two independent stages provided
// - amplitude, frequency, angle differences computed
// - first letter reference, second comparison
// - mode off leaves voltage check only
// - stage one main/y, stage two selectable
`timescale 1ns/1ps
module synchrocheck_close_control
  import synchro_pkg::*;
(
  input  wire logic                    core_clk_i,
  input  wire logic                    rst_i,
  input  wire synchro_pkg::meas_t      main_line_voltage_i,
  input  wire synchro_pkg::meas_t      y_side_line_voltage_i,
  input  wire synchro_pkg::meas_t      z_side_line_voltage_i,
  input  wire synchro_pkg::stage_cfg_t stage1_cfg_i,
  input  wire synchro_pkg::stage_cfg_t stage2_cfg_i,
  input  wire synchro_pkg::pair_sel_t  stage2_pair_i,
  input  wire logic                    stage1_bypass_i,
  input  wire logic                    stage2_bypass_i,
  input  wire logic                    stage1_close_cmd_i,
  input  wire logic                    stage2_close_cmd_i,
  output logic                         stage1_request_o,
  output logic                         stage1_ok_o,
  output logic                         stage1_fail_o,
  output logic                         stage2_request_o,
  output logic                         stage2_ok_o,
  output logic                         stage2_fail_o,
  output logic                         circuit_breaker_close_o
);
  import synchro_pkg::*;

  logic [15:0] tick_div;
  logic        tick;
  meas_t       s2_ref;
  meas_t       s2_cmp;
  stage_out_t  s1_out;
  stage_out_t  s2_out;

  // ************************************************************
  // Millisecond timebase
  // ************************************************************
  // One enable pulse per ms keeps all timers on the single clock
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      tick_div <= '0;
    else if (tick_div == 16'(TICK_CYCLES - 1))
      tick_div <= '0;
    else
      tick_div <= tick_div + 16'h0001;
  end

  assign tick = tick_div == 16'(TICK_CYCLES - 1);

  // ************************************************************
  // Stage two pair selection
  // ************************************************************
  always_comb
  begin
    case (stage2_pair_i)
      PAIR_MAIN_Z:
      begin
        s2_ref = main_line_voltage_i;
        s2_cmp = z_side_line_voltage_i;
      end
      PAIR_Y_Z:
      begin
        s2_ref = y_side_line_voltage_i;
        s2_cmp = z_side_line_voltage_i;
      end
      default:
      begin
        s2_ref = main_line_voltage_i;
        s2_cmp = y_side_line_voltage_i;
      end
    endcase
  end

  // ************************************************************
  // Two independent stages
  // ************************************************************
  // Stage one is fixed to the main and y sides
  sync_stage u_stage1 (
    .core_clk_i  (core_clk_i),
    .rst_i       (rst_i),
    .tick_i      (tick),
    .ref_i       (main_line_voltage_i),
    .cmp_i       (y_side_line_voltage_i),
    .cfg_i       (stage1_cfg_i),
    .bypass_i    (stage1_bypass_i),
    .close_cmd_i (stage1_close_cmd_i),
    .out_o       (s1_out)
  );

  sync_stage u_stage2 (
    .core_clk_i  (core_clk_i),
    .rst_i       (rst_i),
    .tick_i      (tick),
    .ref_i       (s2_ref),
    .cmp_i       (s2_cmp),
    .cfg_i       (stage2_cfg_i),
    .bypass_i    (stage2_bypass_i),
    .close_cmd_i (stage2_close_cmd_i),
    .out_o       (s2_out)
  );

  // ************************************************************
  // Routable indications
  // ************************************************************
  assign stage1_request_o = s1_out.request;
  assign stage1_ok_o      = s1_out.ok;
  assign stage1_fail_o    = s1_out.fail;
  assign stage2_request_o = s2_out.request;
  assign stage2_ok_o      = s2_out.ok;
  assign stage2_fail_o    = s2_out.fail;

  // Close goes to the breaker path only, never to the output matrix
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      circuit_breaker_close_o <= 1'b0;
    else
      circuit_breaker_close_o <= s1_out.close_cmd || s2_out.close_cmd;
  end

endmodule

// >>> bench/synchro_monitor.sv
// Checker on the synchrocheck top ports.
// Assumes it is bound to every instance of the top module.
`timescale 1ns/1ps
module synchro_monitor
  import synchro_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic stage1_bypass_i,
  input wire logic stage2_bypass_i,
  input wire logic stage1_close_cmd_i,
  input wire logic stage2_close_cmd_i,
  input wire logic stage1_request_o,
  input wire logic stage1_ok_o,
  input wire logic stage1_fail_o,
  input wire logic stage2_request_o,
  input wire logic stage2_ok_o,
  input wire logic circuit_breaker_close_o
);
  // Reset aborts every attempt, so no check sees a half-cleared stage
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  property p_req_cmd;
    $rose(stage1_request_o) |-> $past(stage1_close_cmd_i, 2);
  endproperty
  a_req_cmd: assert property (p_req_cmd) else $error("request without command");
  property p_req_ok;
    stage1_request_o |-> !stage1_ok_o;
  endproperty
  a_req_ok: assert property (p_req_ok) else $error("request held while ok");
  property p_req_end;
    // Close or fail comes one edge after the request drops
    $fell(stage1_request_o) |=> circuit_breaker_close_o || stage1_fail_o;
  endproperty
  a_req_end: assert property (p_req_end) else $error("request ended silently");
  property p_fail_cause;
    $rose(stage1_fail_o) |-> $past(stage1_request_o, 2) && !$past(stage1_request_o);
  endproperty
  a_fail_cause: assert property (p_fail_cause) else $error("fail without timeout");
  property p_fail_hold;
    $rose(stage1_fail_o) |=> stage1_fail_o [*8];
  endproperty
  a_fail_hold: assert property (p_fail_hold) else $error("fail pulse too short");
  property p_close_pulse;
    circuit_breaker_close_o |=> !circuit_breaker_close_o;
  endproperty
  a_close_pulse: assert property (p_close_pulse) else $error("close not one cycle");
  property p_close_cause;
    // Breaker close is one register behind the stage close
    circuit_breaker_close_o |-> $past(stage1_request_o, 2) || $past(stage2_request_o, 2)
      || $past(stage1_close_cmd_i, 3) || $past(stage2_close_cmd_i, 3);
  endproperty
  a_close_cause: assert property (p_close_cause) else $error("close without cause");
  property p_bypass1;
    stage1_bypass_i |=> stage1_ok_o;
  endproperty
  a_bypass1: assert property (p_bypass1) else $error("stage one bypass ignored");
  property p_bypass2;
    stage2_bypass_i |=> stage2_ok_o;
  endproperty
  a_bypass2: assert property (p_bypass2) else $error("stage two bypass ignored");
  c_req: cover property ($rose(stage1_request_o));
  c_fail: cover property ($rose(stage1_fail_o));
  c_close: cover property (circuit_breaker_close_o);
  c_ok2: cover property ($rose(stage2_ok_o));
endmodule

bind synchrocheck_close_control synchro_monitor MON (.core_clk_i(core_clk_i), .rst_i(rst_i),
  .stage1_bypass_i(stage1_bypass_i), .stage2_bypass_i(stage2_bypass_i),
  .stage1_close_cmd_i(stage1_close_cmd_i), .stage2_close_cmd_i(stage2_close_cmd_i),
  .stage1_request_o(stage1_request_o), .stage1_ok_o(stage1_ok_o),
  .stage1_fail_o(stage1_fail_o), .stage2_request_o(stage2_request_o),
  .stage2_ok_o(stage2_ok_o), .circuit_breaker_close_o(circuit_breaker_close_o));

// >>> bench/breaker_partner.sv
// Partner model: voltage front ends and breaker close path.
// Assumes amplitudes and y-side frequency and angle come from the bench.
`timescale 1ns/1ps
module breaker_partner
  import synchro_pkg::*;
(
  input  wire logic                            core_clk_i,
  input  wire logic                            rst_i,
  input  wire logic [2:0][synchro_pkg::VW-1:0] amp_i,
  input  wire logic [synchro_pkg::FW-1:0]      freq_y_i,
  input  wire logic [synchro_pkg::AW-1:0]      angle_y_i,
  input  wire logic                            close_i,
  output synchro_pkg::meas_t                   main_o,
  output synchro_pkg::meas_t                   y_o,
  output synchro_pkg::meas_t                   z_o,
  output logic [7:0]                           closes_o
);
  // Front ends refresh once a cycle; main and z sit at 50 Hz, zero angle
  always_ff @(posedge core_clk_i)
  begin
    main_o <= '{amp_i[0], 16'hC350, 16'h0000};
    y_o    <= '{amp_i[1], freq_y_i, angle_y_i};
    z_o    <= '{amp_i[2], 16'hC350, 16'h0000};
  end
  // One close pulse is one breaker operation
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      closes_o <= 8'h00;
    else if (close_i)
      closes_o <= closes_o + 8'h01;
  end
endmodule

// >>> bench/synchrocheck_close_control_tb.sv
// Testbench for the synchrocheck close control.
// Assumes the partner model feeds measurements and counts breaker closes.
`timescale 1ns/1ps
module synchrocheck_close_control_tb;
  import synchro_pkg::*;
  localparam logic [TW-1:0] BIG = 20'h0_2710;
  localparam logic [VW-1:0] LIVE = 16'h1000;
  localparam logic [VW-1:0] DEAD = 16'h00FF;
  localparam logic [FW-1:0] F0 = 16'hC350;
  logic               core_clk_i = 0;
  logic               rst_i = 1;
  meas_t              main_m, y_m, z_m;
  stage_cfg_t         cfg1, cfg2;
  pair_sel_t          pair = PAIR_MAIN_Y;
  logic               byp1 = 0, byp2 = 0, cmd1 = 0, cmd2 = 0;
  logic               req1, ok1, fail1, req2, ok2, fail2, cb_close;
  logic [2:0][VW-1:0] amp = {LIVE, LIVE, LIVE};
  logic [FW-1:0]      freq_y = F0;
  logic [AW-1:0]      angle_y = 16'h0000;
  logic [7:0]         closes;
  int                 bad_count = 0, n_compared = 0;
  logic [VW-1:0]      lvl [3] = '{16'h00FF, 16'h0100, 16'h0801};

  synchrocheck_close_control DUT (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .main_line_voltage_i(main_m), .y_side_line_voltage_i(y_m), .z_side_line_voltage_i(z_m),
    .stage1_cfg_i(cfg1), .stage2_cfg_i(cfg2), .stage2_pair_i(pair),
    .stage1_bypass_i(byp1), .stage2_bypass_i(byp2),
    .stage1_close_cmd_i(cmd1), .stage2_close_cmd_i(cmd2),
    .stage1_request_o(req1), .stage1_ok_o(ok1), .stage1_fail_o(fail1),
    .stage2_request_o(req2), .stage2_ok_o(ok2), .stage2_fail_o(fail2),
    .circuit_breaker_close_o(cb_close));
  breaker_partner PARTNER (.core_clk_i(core_clk_i), .rst_i(rst_i), .amp_i(amp),
    .freq_y_i(freq_y), .angle_y_i(angle_y), .close_i(cb_close),
    .main_o(main_m), .y_o(y_m), .z_o(z_m), .closes_o(closes));

  initial forever #20 core_clk_i = ~core_clk_i;

  function automatic stage_cfg_t cfg(logic en, logic [2:0] sel, sync_mode_t m, logic [TW-1:0] t);
    return '{en, sel, m, 16'h0100, 16'h0800, 16'h0200, 16'h0064, 16'h03E8, 20'h0_0064, t};
  endfunction
  // Dead is level 0, live is level 2; level 1 sits on the dead limit and is neither
  function automatic logic exp_v(logic [2:0] s, int r, int c);
    return (s[0] && r == 0 && c == 0) || (s[1] && r == 0 && c == 2) || (s[2] && r == 2 && c == 0);
  endfunction
  task automatic check(string what, logic exp, logic seen);
    n_compared++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch %s expected %b seen %b", what, exp, seen);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  task automatic setup(stage_cfg_t c, logic [VW-1:0] a0, a1, logic [FW-1:0] f, logic [AW-1:0] g);
    @(posedge core_clk_i);
    cfg1 <= c;
    amp[0] <= a0;
    amp[1] <= a1;
    freq_y <= f;
    angle_y <= g;
    tick(3);
  endtask
  task automatic command(bit two);
    @(posedge core_clk_i);
    if (two) cmd2 <= 1; else cmd1 <= 1;
    @(posedge core_clk_i);
    cmd1 <= 0;
    cmd2 <= 0;
  endtask
  // Level test, so a fail that rose before the wait began still counts
  task automatic wait_for(bit on_fail, int lim);
    repeat (lim)
    begin
      @(posedge core_clk_i);
      #1;
      if ((on_fail ? fail1 : cb_close) === 1'b1)
        return;
    end
    bad_count++;
    $display("mismatch %s expected 1 seen 0", on_fail ? "fail1" : "close");
    results();
  endtask
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  initial
  begin
    cfg1 = cfg(0, 3'h0, SMODE_OFF, BIG);
    cfg2 = cfg1;
    repeat (6) @(posedge core_clk_i);
    rst_i <= 0;
    for (int s = 0; s < 9; s++)
      for (int k = 1; k < 8; k++)
      begin
        setup(cfg(1, k[2:0], SMODE_OFF, BIG), lvl[s % 3], lvl[s / 3], F0, 16'h0000);
        check("ok1 vcheck", exp_v(k[2:0], s % 3, s / 3), ok1);
      end
    setup(cfg(0, 3'h0, SMODE_ASYNC, BIG), LIVE, LIVE, F0, 16'h01F4);
    check("ok1 async in", 1, ok1);
    setup(cfg(0, 3'h0, SMODE_ASYNC, BIG), LIVE, LIVE, F0, 16'h07D0);
    check("ok1 async angle", 0, ok1);
    setup(cfg(0, 3'h0, SMODE_ASYNC, BIG), LIVE, LIVE, 16'hC3E8, 16'h0000);
    check("ok1 async freq", 0, ok1);
    setup(cfg(0, 3'h0, SMODE_ASYNC, BIG), LIVE, 16'h1400, F0, 16'h0000);
    check("ok1 async amp", 0, ok1);
    setup(cfg(0, 3'h0, SMODE_ASYNC, BIG), LIVE, DEAD, F0, 16'h0000);
    check("ok1 async dead", 0, ok1);
    setup(cfg(0, 3'h0, SMODE_SYNC, BIG), LIVE, LIVE, F0, 16'h0064);
    check("ok1 sync in", 1, ok1);
    setup(cfg(0, 3'h0, SMODE_SYNC, BIG), LIVE, LIVE, F0, 16'h01F4);
    check("ok1 sync out", 0, ok1);
    // 50 mHz slip over 100 ms close time advances the aim by 1.80 degrees
    setup(cfg(0, 3'h0, SMODE_SYNC, BIG), LIVE, LIVE, 16'hC382, 16'h012C);
    check("ok1 sync advance", 1, ok1);
    setup(cfg(1, 3'h2, SMODE_ASYNC, BIG), LIVE, LIVE, F0, 16'h0064);
    check("ok1 combined", 1, ok1);
    setup(cfg(0, 3'h0, SMODE_OFF, BIG), LIVE, LIVE, F0, 16'h0000);
    check("ok1 mode off", 0, ok1);
    setup(cfg(1, 3'h2, SMODE_OFF, BIG), LIVE, LIVE, F0, 16'h0000);
    command(0);
    tick(2);
    check("req1 pending", 1, req1);
    command(0);
    tick(2);
    check("req1 kept", 1, req1);
    check("no close", 1, closes === 8'h00);
    @(posedge core_clk_i);
    amp[0] <= DEAD;
    wait_for(0, 10);
    check("req1 done", 0, req1);
    command(0);
    wait_for(0, 3);
    check("req1 skipped", 0, req1);
    setup(cfg(0, 3'h0, SMODE_OFF, BIG), LIVE, LIVE, F0, 16'h0000);
    byp1 <= 1;
    tick(2);
    check("ok1 bypass", 1, ok1);
    command(0);
    wait_for(0, 3);
    byp1 <= 0;
    cfg2 <= cfg(1, 3'h2, SMODE_OFF, BIG);
    amp <= {DEAD, LIVE, DEAD};
    for (int p = 0; p < 3; p++)
    begin
      @(posedge core_clk_i);
      pair <= pair_sel_t'(p);
      tick(3);
      check("ok2 pair", p == 0, ok2);
    end
    byp2 <= 1;
    tick(2);
    check("ok2 bypass", 1, ok2);
    byp2 <= 0;
    pair <= PAIR_MAIN_Y;
    tick(3);
    command(1);
    wait_for(0, 4);
    // Stage two pending request, released by switching to a synced pair
    pair <= PAIR_MAIN_Z;
    tick(3);
    command(1);
    tick(2);
    check("req2 pending", 1, req2);
    @(posedge core_clk_i);
    pair <= PAIR_MAIN_Y;
    wait_for(0, 4);
    check("req2 done", 0, req2);
    check("fail2 idle", 0, fail2);
    setup(cfg(1, 3'h2, SMODE_OFF, 20'h0_0002), LIVE, LIVE, F0, 16'h0000);
    command(0);
    repeat (30000) @(posedge core_clk_i);
    command(0);
    wait_for(1, 20200);
    check("req1 timed out", 0, req1);
    check("close count", 1, closes === 8'h05);
    tick(100);
    check("fail1 held", 1, fail1);
    rst_i <= 1;
    tick(2);
    rst_i <= 0;
    check("fail1 reset", 0, fail1);
    check("req1 reset", 0, req1);
    results();
  end
endmodule
